// ---- hdl/empi_pkg.sv ----
package empi_pkg;

	// Register addresses on the processor bus
	localparam logic [15:0] PAGE_ONE_ADDR = 16'hc018;
	localparam logic [15:0] PAGE_TWO_ADDR = 16'hc01a;
	localparam logic [15:0] EXT_CTRL_ADDR = 16'hc03a;

	// Address regions
	localparam logic [15:0] RAM_LO = 16'h4000;
	localparam logic [15:0] RAM_HI = 16'h7fff;
	localparam logic [15:0] RAM_HI_MERGED = 16'hbfff;
	localparam logic [15:0] WIN_LO = 16'h8000;
	localparam logic [15:0] WIN_ONE_HI = 16'h9fff;
	localparam logic [15:0] WIN_TWO_LO = 16'ha000;
	localparam logic [15:0] WIN_HI = 16'hbfff;
	localparam logic [15:0] HOLE_LO = 16'hc000;
	localparam logic [15:0] HOLE_HI = 16'hc0ff;
	localparam logic [15:0] ROM_LO = 16'hc100;
	localparam logic [15:0] ROM_HI = 16'hdfff;

	// Six page bits above a 13-bit window give 64 x 8K = 512K bytes
	localparam int PAGE_BITS = 6;
	localparam int WIN_SHIFT = 13;
	localparam int UPPER_LO = 15;

	// Control register layout
	localparam int CTRL_RAM_MERGE_POS = 0;
	localparam int CTRL_ROM_MERGE_POS = 1;
	localparam int CTRL_WIDE_POS = 2;
	localparam int CTRL_WS_POS = 4;
	localparam int CTRL_WS_W = 3;
	localparam int CTRL_UPPER_EN_POS = 8;
	localparam logic [15:0] CTRL_MASK = 16'h0177;

	// Reset values
	localparam logic [15:0] CTRL_RST = 16'h0070;
	localparam logic [15:0] PAGE_RST = 16'h0000;
	localparam logic [18:0] ADDR_RST = 19'h78000;

	// Timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int WS_STEP_NS = 21;
	localparam int WS_STEP_CYC = (WS_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_BASE_CYC = 1;
	localparam int MIN_WAIT = 1;

	typedef enum logic [1:0] {EMPI_SEL_NONE, EMPI_SEL_PAGED, EMPI_SEL_RAM, EMPI_SEL_ROM}
		empi_sel_t;
	typedef enum logic [1:0] {EMPI_IDLE, EMPI_STROBE, EMPI_GAP} empi_state_t;

	typedef struct packed {
		empi_state_t st;
		logic [15:0] page_one;
		logic [15:0] page_two;
		logic [15:0] ctrl;
		logic [18:0] addr;
		empi_sel_t sel;
		logic [3:0] cnt;
		logic we;
		logic wide;
		logic hi;
		logic [1:0] lanes;
		logic [15:0] wdata;
		logic [15:0] rdata;
		logic ready;
		logic fault;
	} empi_regs_t;

	function automatic logic empi_in(input logic [15:0] a, input logic [15:0] lo,
		input logic [15:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction

	// Paged window wins over merged RAM and ROM ranges
	function automatic empi_sel_t empi_decode(input logic [15:0] a, input logic ram_m,
		input logic rom_m);
		empi_sel_t s;
		s = EMPI_SEL_NONE;
		// (R10) (R16) window always paged
		// (R12) (R13) ram, rom ranges
		if (empi_in(a, WIN_LO, WIN_HI)) begin
			s = EMPI_SEL_PAGED;
		end else if (empi_in(a, RAM_LO, ram_m ? RAM_HI_MERGED : RAM_HI)) begin
			s = EMPI_SEL_RAM;
		end else if (empi_in(a, rom_m ? WIN_LO : ROM_LO, ROM_HI) &&
			!empi_in(a, HOLE_LO, HOLE_HI)) begin
			s = EMPI_SEL_ROM;
		end
		return s;
	endfunction

endpackage

// ---- hdl/empi_addr_map.sv ----
`timescale 1ns/10ps
module empi_addr_map import empi_pkg::*; (
	input wire logic [15:0] i_cpu_addr,
	input wire logic i_hi_byte,
	input wire logic i_wide,
	input wire logic i_paged,
	input wire logic [15:0] i_page_one,
	input wire logic [15:0] i_page_two,
	input wire logic i_upper_en,
	output logic [18:0] o_ext_addr
);

	always_comb begin
		o_ext_addr = {3'h0, i_cpu_addr};
		// (R6) six page bits, 512K
		if (i_paged) begin
			o_ext_addr = {(i_cpu_addr < WIN_TWO_LO) ? i_page_one[PAGE_BITS-1:0] :
				i_page_two[PAGE_BITS-1:0], i_cpu_addr[WIN_SHIFT-1:0]};
		end
		// In byte mode bit 0 selects the byte; in word mode the pin is a lane enable
		if (!i_wide) begin
			o_ext_addr[0] = i_hi_byte;
		end
		if (!i_upper_en) begin
			o_ext_addr[18:UPPER_LO] = 4'hf;
		end
	end

endmodule

// ---- hdl/empi_ctrl.sv ----
// How it works
// (R1) The processor sees one flat byte space from 0x0000 to 0xFFFF.
// (R2) External memory may be 8 or 16 bits wide, code or data.
// (R3) Read data is taken as the strobe rises; at least one wait state.
// (R4) Up to seven extra wait states, each adding 21 ns; the code rounds each up to one 40 ns clock.
// (R5) Software changes wait states only while running from internal memory.
// (R6) Paging reaches up to 512K bytes of external storage.
// (R7) First page register at 0xC018 extends window 0x8000-0x9FFF.
// (R8) Second page register at 0xC01A extends window 0xA000-0xBFFF.
// (R9) While the paged select is low, upper address comes from the page register.
// (R10) Paged select is active for 0x8000-0xBFFF regardless of merge.
// (R11) Merge options live in the control register at 0xC03A.
// (R12) RAM select covers 0x4000-0x7FFF, or 0x4000-0xBFFF when merged.
// (R13) ROM select covers 0xC100-0xDFFF, or 0x8000-0xDFFF minus 0xC000-0xC0FF.
// (R14) Instruction fetches from 0xC000-0xC0FF are never served.
// (R15) Address lines 18 to 15 stay high until software enables them.
// (R16) Both page windows are always mapped; paging cannot be switched off.
// (R17) Selects are active low, at most one at a time, paged first.
`timescale 1ns/10ps
module empi_ctrl import empi_pkg::*; (
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	input wire logic i_cpu_req,
	input wire logic i_cpu_we,
	input wire logic i_cpu_fetch,
	input wire logic [15:0] i_cpu_addr,
	input wire logic [1:0] i_cpu_byte_en,
	input wire logic [15:0] i_cpu_wdata,
	output logic o_cpu_ready,
	output logic [15:0] o_cpu_rdata,
	output logic o_fetch_fault,
	output logic [18:1] o_ext_addr,
	output logic o_low_byte_lane_n,
	output logic o_high_byte_lane_n,
	output logic o_rd_n,
	output logic o_wr_n,
	output logic o_paged_window_select_n,
	output logic o_ext_ram_select_n,
	output logic o_ext_rom_select_n,
	output logic [15:0] o_data_out,
	output logic o_data_oe,
	input wire logic [15:0] i_data_in
);

	localparam empi_regs_t REGS_RST = '{st: EMPI_IDLE, page_one: PAGE_RST, page_two: PAGE_RST,
		ctrl: CTRL_RST, addr: ADDR_RST, sel: EMPI_SEL_NONE, cnt: 4'h0, we: 1'b0, wide: 1'b0,
		hi: 1'b0, lanes: 2'h0, wdata: 16'h0000, rdata: 16'h0000, ready: 1'b0, fault: 1'b0};

	logic [1:0] rst_sync;
	logic rst_b;
	empi_regs_t r;
	empi_regs_t next_r;
	empi_sel_t dec;
	logic [18:0] map_addr;
	logic active;
	logic last_byte;

	function automatic logic [3:0] strobe_cycles(input logic [15:0] ctrl);
		return 4'(STROBE_BASE_CYC +
			(MIN_WAIT + int'(ctrl[CTRL_WS_POS +: CTRL_WS_W])) * WS_STEP_CYC);
	endfunction

	function automatic logic [15:0] merge_bytes(input logic [15:0] old_v,
		input logic [15:0] new_v, input logic [1:0] be);
		return {be[1] ? new_v[15:8] : old_v[15:8], be[0] ? new_v[7:0] : old_v[7:0]};
	endfunction

	// Release is synchronised so no flop sees reset drop near a clock edge
	always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_b = rst_sync[1];

	// (R1) flat decode, merges from control bits
	assign dec = empi_decode(i_cpu_addr, r.ctrl[CTRL_RAM_MERGE_POS], r.ctrl[CTRL_ROM_MERGE_POS]);

	// (R9) page register drives upper address
	empi_addr_map u_map (
		.i_cpu_addr(i_cpu_addr),
		.i_hi_byte(!i_cpu_byte_en[0]),
		.i_wide(r.ctrl[CTRL_WIDE_POS]),
		.i_paged(dec == EMPI_SEL_PAGED),
		.i_page_one(r.page_one),
		.i_page_two(r.page_two),
		.i_upper_en(r.ctrl[CTRL_UPPER_EN_POS]),
		.o_ext_addr(map_addr)
	);

	// (R2) a byte-wide part needs a second strobe for the high byte
	assign last_byte = r.wide || r.hi || (r.lanes != 2'b11);

	always_comb begin
		next_r = r;
		next_r.ready = 1'b0;
		next_r.fault = 1'b0;
		case (r.st)
			EMPI_IDLE: begin
				if (i_cpu_req) begin
					// (R14) hole fetch refused
					if (i_cpu_fetch && empi_in(i_cpu_addr, HOLE_LO, HOLE_HI)) begin
						next_r.ready = 1'b1;
						next_r.fault = 1'b1;
						next_r.rdata = 16'h0000;
					end else if (dec != EMPI_SEL_NONE) begin
						next_r.st = EMPI_STROBE;
						next_r.sel = dec;
						next_r.we = i_cpu_we;
						next_r.wide = r.ctrl[CTRL_WIDE_POS];
						next_r.hi = !r.ctrl[CTRL_WIDE_POS] && !i_cpu_byte_en[0];
						next_r.lanes = i_cpu_byte_en;
						next_r.wdata = i_cpu_wdata;
						next_r.addr = map_addr;
						next_r.rdata = 16'h0000;
						// (R4) strobe stretched by wait states
						next_r.cnt = strobe_cycles(r.ctrl) - 4'h1;
					end else begin
						next_r.ready = 1'b1;
						next_r.rdata = 16'h0000;
						// (R7) first page register
						if (i_cpu_addr == PAGE_ONE_ADDR) begin
							next_r.rdata = r.page_one;
							if (i_cpu_we) begin
								next_r.page_one = merge_bytes(r.page_one, i_cpu_wdata, i_cpu_byte_en);
							end
						end
						// (R8) second page register
						if (i_cpu_addr == PAGE_TWO_ADDR) begin
							next_r.rdata = r.page_two;
							if (i_cpu_we) begin
								next_r.page_two = merge_bytes(r.page_two, i_cpu_wdata, i_cpu_byte_en);
							end
						end
						// (R11) merge and wait-state control
						if (i_cpu_addr == EXT_CTRL_ADDR) begin
							next_r.rdata = r.ctrl;
							if (i_cpu_we) begin
								next_r.ctrl = merge_bytes(r.ctrl, i_cpu_wdata, i_cpu_byte_en) & CTRL_MASK;
							end
						end
					end
				end
			end
			EMPI_STROBE: begin
				if (r.cnt == 4'h0) begin
					// (R3) capture in the cycle before the strobe rises
					if (!r.we) begin
						if (r.wide) begin
							next_r.rdata = i_data_in;
						end else if (r.hi) begin
							next_r.rdata[15:8] = i_data_in[7:0];
						end else begin
							next_r.rdata[7:0] = i_data_in[7:0];
						end
					end
					if (last_byte) begin
						next_r.st = EMPI_IDLE;
						next_r.sel = EMPI_SEL_NONE;
						next_r.ready = 1'b1;
					end else begin
						next_r.st = EMPI_GAP;
						next_r.hi = 1'b1;
						next_r.addr[0] = 1'b1;
					end
				end else begin
					next_r.cnt = r.cnt - 4'h1;
				end
			end
			EMPI_GAP: begin
				// Strobe high for one cycle so the byte part sees two accesses
				next_r.st = EMPI_STROBE;
				next_r.cnt = strobe_cycles(r.ctrl) - 4'h1;
			end
			default: begin
				next_r.st = EMPI_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			r <= REGS_RST;
		end else begin
			r <= next_r;
		end
	end

	assign active = (r.st != EMPI_IDLE);
	assign o_cpu_ready = r.ready;
	assign o_cpu_rdata = r.rdata;
	assign o_fetch_fault = r.fault;
	// (R15) upper lines parked high until enabled
	assign o_ext_addr = r.addr[18:1];
	assign o_low_byte_lane_n = r.wide ? !(active && r.lanes[0]) : r.addr[0];
	assign o_high_byte_lane_n = r.wide ? !(active && r.lanes[1]) : 1'b1;
	// Strobes decode the state and direction flops only; no input reaches them combinationally
	assign o_rd_n = !(r.st == EMPI_STROBE && !r.we);
	assign o_wr_n = !(r.st == EMPI_STROBE && r.we);
	// (R17) one active-low select per access
	assign o_paged_window_select_n = !(active && r.sel == EMPI_SEL_PAGED);
	assign o_ext_ram_select_n = !(active && r.sel == EMPI_SEL_RAM);
	assign o_ext_rom_select_n = !(active && r.sel == EMPI_SEL_ROM);
	assign o_data_out = r.wide ? r.wdata : {8'h00, r.hi ? r.wdata[15:8] : r.wdata[7:0]};
	assign o_data_oe = active && r.we;

	logic [3:0] h_len;
	always_ff @(posedge i_sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			h_len <= 4'h0;
		end else if (r.st == EMPI_STROBE) begin
			h_len <= h_len + 4'h1;
		end else begin
			h_len <= 4'h0;
		end
	end

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!rst_b);

	sequence s_start(logic [15:0] lo, logic [15:0] hi);
		r.st == EMPI_IDLE && i_cpu_req && !i_cpu_fetch && empi_in(i_cpu_addr, lo, hi);
	endsequence
	sequence s_strobe_end;
		r.st == EMPI_STROBE && next_r.st != EMPI_STROBE;
	endsequence

	a_strobe_length: assert property (s_strobe_end |-> // (R4)
		(h_len + 4'h1 == strobe_cycles(r.ctrl)) && h_len >= 4'h1)
		else $error("strobe length does not match wait-state setting");
	a_ready_after_strobe: assert property ((s_strobe_end and ##0 last_byte) |=> // (R3)
		o_cpu_ready && o_rd_n && o_wr_n)
		else $error("ready missing after final strobe");
	a_one_select: assert property ($countones({o_paged_window_select_n, // (R17)
		o_ext_ram_select_n, o_ext_rom_select_n}) >= 2)
		else $error("more than one chip select active");
	a_paged_select_range: assert property (s_start(WIN_LO, WIN_HI) |=> // (R10)
		!o_paged_window_select_n [*2])
		else $error("paged select not held for window access");
	a_page_one_addr: assert property ((s_start(WIN_LO, WIN_ONE_HI) and // (R7)
		##0 r.ctrl[CTRL_UPPER_EN_POS]) |=> o_ext_addr[18:13] == r.page_one[PAGE_BITS-1:0])
		else $error("first window upper address wrong");
	a_page_two_addr: assert property ((s_start(WIN_TWO_LO, WIN_HI) and // (R8)
		##0 r.ctrl[CTRL_UPPER_EN_POS]) |=> o_ext_addr[18:13] == r.page_two[PAGE_BITS-1:0])
		else $error("second window upper address wrong");
	a_ram_low_range: assert property (s_start(RAM_LO, RAM_HI) |=> // (R12)
		!o_ext_ram_select_n && o_ext_rom_select_n)
		else $error("ram select missing");
	a_rom_base_range: assert property (s_start(ROM_LO, ROM_HI) |=> // (R13)
		!o_ext_rom_select_n && o_ext_ram_select_n)
		else $error("rom select missing");
	a_hole_fetch_blocked: assert property ((r.st == EMPI_IDLE && i_cpu_req && // (R14)
		i_cpu_fetch && empi_in(i_cpu_addr, HOLE_LO, HOLE_HI)) |=>
		o_fetch_fault && o_cpu_rdata == 16'h0000 && o_rd_n ##1 !o_cpu_ready)
		else $error("fetch from hole was served");
	a_upper_held_high: assert property ((active && !r.ctrl[CTRL_UPPER_EN_POS]) |-> // (R15)
		o_ext_addr[18:UPPER_LO] == 4'hf)
		else $error("upper address not parked high");
	a_ctrl_write: assert property ((r.st == EMPI_IDLE && i_cpu_req && i_cpu_we && // (R11)
		i_cpu_addr == EXT_CTRL_ADDR && i_cpu_byte_en == 2'b11) |=>
		r.ctrl == ($past(i_cpu_wdata) & CTRL_MASK))
		else $error("control register write lost");

endmodule

// ---- tb/empi_sram_model.sv ----
`timescale 1ns/10ps
module empi_sram_model #(parameter int ACC_NS = 12) (
	input wire logic i_sys_clk,
	input wire logic i_wide,
	input wire logic i_sel_n,
	input wire logic [18:1] i_addr,
	input wire logic i_low_lane_n,
	input wire logic i_high_lane_n,
	input wire logic i_rd_n,
	input wire logic i_wr_n,
	input wire logic [15:0] i_data,
	output logic [15:0] o_data
);
	logic [7:0] mem [0:524287];
	logic [15:0] last = 16'h0000;
	logic [15:0] rd_val;
	logic [18:0] b0;
	assign b0 = i_wide ? {i_addr, 1'b0} : {i_addr, i_low_lane_n};
	assign rd_val = i_wide ? {mem[b0 | 19'h1], mem[b0]} : {~last[15:8], mem[b0]};
	always @(posedge i_sys_clk) begin
		if (!i_sel_n && !i_wr_n) begin
			if (!i_wide || !i_low_lane_n) begin
				mem[b0] <= i_data[7:0];
			end
			if (i_wide && !i_high_lane_n) begin
				mem[b0 | 19'h1] <= i_data[15:8];
			end
		end
		if (!i_sel_n && !i_rd_n) begin
			last <= rd_val;
		end
	end
	// data held until strobe rises
	// Released pins show the inverse so a stale value never passes
	assign #(ACC_NS) o_data = (!i_rd_n && !i_sel_n) ? rd_val : ~last;
endmodule

// ---- tb/ext_memory_paged_interface_tb_top.sv ----
`timescale 1ns/10ps
module ext_memory_paged_interface_tb_top import empi_pkg::*;;
	logic sys_clk, rst_b, req, we, fetch, ready, fault, lo_n, hi_n, rd_n, wr_n;
	logic pg_n, ram_n, rom_n, oe, wide_mode;
	logic [1:0] be, g_sel;
	logic [15:0] addr, wdata, rdata, dout, din, g_rdata;
	logic [18:1] ext_addr, g_addr;
	logic g_fault, g_multi, g_oe;
	int fails = 0, n_checks = 0, cyc = 0, g_n;
	logic [15:0] addrs [10] = '{16'h3fff, 16'h4000, 16'h7fff, 16'h8000, 16'h9fff,
		16'hbfff, 16'hc0ff, 16'hc100, 16'hdfff, 16'he000};

	empi_ctrl i_empi_ctrl (.i_sys_clk(sys_clk), .i_rst_b(rst_b), .i_cpu_req(req),
		.i_cpu_we(we), .i_cpu_fetch(fetch), .i_cpu_addr(addr), .i_cpu_byte_en(be),
		.i_cpu_wdata(wdata), .o_cpu_ready(ready), .o_cpu_rdata(rdata),
		.o_fetch_fault(fault), .o_ext_addr(ext_addr), .o_low_byte_lane_n(lo_n),
		.o_high_byte_lane_n(hi_n), .o_rd_n(rd_n), .o_wr_n(wr_n),
		.o_paged_window_select_n(pg_n), .o_ext_ram_select_n(ram_n),
		.o_ext_rom_select_n(rom_n), .o_data_out(dout), .o_data_oe(oe), .i_data_in(din));
	empi_sram_model i_empi_sram_model (.i_sys_clk(sys_clk), .i_wide(wide_mode),
		.i_sel_n(pg_n & ram_n & rom_n), .i_addr(ext_addr), .i_low_lane_n(lo_n),
		.i_high_lane_n(hi_n), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_data(dout), .o_data(din));

	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	task tally_and_finish;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// Generous ceiling: a full run needs a few hundred cycles
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			tally_and_finish;
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	function automatic logic [1:0] exp_sel(logic [15:0] a, logic rm, logic om);
		if (a >= 16'h8000 && a <= 16'hbfff) return 2'h1;
		if (a >= 16'h4000 && a <= (rm ? 16'hbfff : 16'h7fff)) return 2'h2;
		if (a >= (om ? 16'h8000 : 16'hc100) && a <= 16'hdfff && !(a >= 16'hc000 && a <= 16'hc0ff))
			return 2'h3;
		return 2'h0;
	endfunction

	// Holds the request until ready is seen, sampling pins mid-cycle
	task acc(input logic w, input logic f, input logic [15:0] a, input logic [1:0] b,
		input logic [15:0] d);
		int k;
		@(negedge sys_clk);
		g_n = 0;
		g_sel = 2'h0;
		g_multi = 1'b0;
		g_oe = 1'b0;
		req = 1'b1;
		we = w;
		fetch = f;
		addr = a;
		be = b;
		wdata = d;
		for (k = 0; k < 100; k++) begin
			@(negedge sys_clk);
			if (!rd_n || !wr_n) begin
				g_n++;
				g_addr = ext_addr;
				g_sel = !pg_n ? 2'h1 : !ram_n ? 2'h2 : !rom_n ? 2'h3 : 2'h0;
				if ($countones({~pg_n, ~ram_n, ~rom_n}) > 1) g_multi = 1'b1;
			end
			// Data pins driven throughout a write strobe, never under a read strobe
			if ((!wr_n && oe !== 1'b1) || (!rd_n && oe !== 1'b0)) g_oe = 1'b1;
			if (ready === 1'b1) break;
		end
		g_rdata = rdata;
		g_fault = fault;
		req = 1'b0;
		if (k == 100) fails++;
		chk(g_oe, 1'b0);
	endtask

	task wr(input logic [15:0] a, input logic [15:0] d);
		acc(1'b1, 1'b0, a, 2'b11, d);
		if (a == EXT_CTRL_ADDR) wide_mode = d[CTRL_WIDE_POS];
	endtask

	task rd(input logic [15:0] a);
		acc(1'b0, 1'b0, a, 2'b11, 16'h0000);
	endtask

	initial begin
		rst_b = 1'b0;
		{req, we, fetch, be, addr, wdata, wide_mode} = '0;
		repeat (2) @(posedge sys_clk);
		@(negedge sys_clk);
		rst_b = 1'b1;
		repeat (3) @(negedge sys_clk);
		chk(ext_addr, 18'h3c000);
		chk({pg_n, ram_n, rom_n, rd_n, wr_n, oe}, 6'h3e);
		rd(EXT_CTRL_ADDR);
		chk(g_rdata, CTRL_RST);
		rd(PAGE_ONE_ADDR);
		chk(g_rdata, PAGE_RST);
		wr(EXT_CTRL_ADDR, 16'hffff);
		rd(EXT_CTRL_ADDR);
		chk(g_rdata, CTRL_MASK);
		$display("test registers done");
		wr(EXT_CTRL_ADDR, 16'h0004);
		rd(16'h4002);
		chk(g_addr[18:15], 4'hf);
		chk(g_n, 2);
		$display("test upper lines done");
		// Wait states change only between accesses
		for (int ws = 0; ws < 8; ws++) begin
			wr(EXT_CTRL_ADDR, 16'h0104 | (16'(ws) << 4));
			rd(16'h4000);
			chk(g_n, 2 + ws);
		end
		$display("test wait states done");
		for (int m = 0; m < 4; m++) begin
			wr(EXT_CTRL_ADDR, 16'h0104 | 16'(m));
			foreach (addrs[i]) begin
				rd(addrs[i]);
				chk(g_sel, exp_sel(addrs[i], m[0], m[1]));
				chk(g_multi, 1'b0);
			end
		end
		$display("test decode done");
		wr(EXT_CTRL_ADDR, 16'h0104);
		wr(PAGE_ONE_ADDR, 16'h002a);
		wr(PAGE_TWO_ADDR, 16'h002a);
		wr(16'h8002, 16'h1234);
		chk(g_addr, {6'h2a, 12'h001});
		wr(16'ha002, 16'h5678);
		chk(g_addr, {6'h2a, 12'h001});
		rd(16'h8002);
		chk(g_rdata, 16'h5678);
		// Low lane only: the high byte must stay untouched
		acc(1'b1, 1'b0, 16'h8002, 2'b01, 16'h00aa);
		rd(16'h8002);
		chk(g_rdata, 16'h56aa);
		wr(PAGE_TWO_ADDR, 16'h003f);
		wr(16'hbffe, 16'hcafe);
		chk(g_addr, {6'h3f, 12'hfff});
		$display("test paging done");
		wr(EXT_CTRL_ADDR, 16'h0100);
		wr(16'h4010, 16'hbeef);
		chk(g_n, 4);
		rd(16'h4010);
		chk(g_rdata, 16'hbeef);
		// A lone high byte takes one strobe at the odd address
		acc(1'b1, 1'b0, 16'h4010, 2'b10, 16'h5500);
		chk(g_n, 2);
		rd(16'h4010);
		chk(g_rdata, 16'h55ef);
		$display("test narrow bus done");
		acc(1'b0, 1'b1, 16'hc080, 2'b11, 16'h0000);
		chk({g_fault, g_rdata}, 17'h10000);
		chk(g_n, 0);
		acc(1'b0, 1'b1, 16'hc100, 2'b11, 16'h0000);
		chk(g_fault, 1'b0);
		chk(g_n, 4);
		$display("test code hole done");
		tally_and_finish;
	end
endmodule
